// [sim/pin_change_notify_and_remap_tb.sv]
// Self-checking bench for the pin notify block
`timescale 1ns/1ns
`include "pin_notify_defs.svh"
module pin_change_notify_and_remap_tb
    import pin_notify_pkg::*;
;
    logic         mclk = 1'b0;
    logic         reset_n = 1'b0;
    bus_req_type  req = '0;
    logic [15:0]  rd_data, pu, pd, port_lvl;
    logic [15:0]  drv_val = 16'h0000;
    logic         sleep_mode = 1'b0;
    logic [181:0] rp_val = '0;
    logic [181:0] rp_lvl;
    logic         ext1, ext2, irq;
    out_func_type ofunc;
    int           failures = 0;
    int           compares = 0;
    int           cycles = 0;

    pin_change_notify_and_remap pin_change_notify_and_remap_i (
        .mclk(mclk), .reset_n(reset_n), .bus_req(req), .rd_data(rd_data),
        .port_in(port_lvl), .sleep_mode(sleep_mode),
        .weak_pullup_enable_bits(pu), .weak_pulldown_enable_bits(pd),
        .rp_in(rp_lvl), .external_interrupt_one(ext1),
        .external_interrupt_two(ext2), .out_func(ofunc),
        .pin_change_notify(irq));
    // Bench keeps every port pin driven, so pulls stay unused on outputs
    pin_notify_partner pin_notify_partner_i (
        .drv_val(drv_val), .drv_en(16'hFFFF), .pu_en(pu), .pd_en(pd),
        .rp_val(rp_val), .port_lvl(port_lvl), .rp_lvl(rp_lvl));

    initial begin
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        logic [15:0] d;
        rd(`OFS_EXTERNAL_INTERRUPT_ONE_SEL, d); check(d, 16'h0000);
        rd(`OFS_EXTERNAL_INTERRUPT_TWO_SEL, d); check(d, 16'h0000);
        rd(`OFS_OUT_SEL, d); check(d, 16'h0000);
        check({4'h0, ofunc}, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task t_remap;
        logic [15:0] d;
        wr(`OFS_EXTERNAL_INTERRUPT_ONE_SEL, 16'hFFFF);
        wr(`OFS_EXTERNAL_INTERRUPT_TWO_SEL, 16'hFFFF);
        wr(`OFS_OUT_SEL, 16'hFFFF);
        rd(`OFS_EXTERNAL_INTERRUPT_ONE_SEL, d); check(d, 16'hFF00);
        rd(`OFS_EXTERNAL_INTERRUPT_TWO_SEL, d); check(d, 16'h00FF);
        rd(`OFS_OUT_SEL, d); check(d, 16'h3F3F);
        wr(`OFS_OUT_SEL, 16'h2A15);
        cyc(1);
        check({10'h000, ofunc.pin177_output_func_field}, 16'h002A);
        check({10'h000, ofunc.pin176_output_func_field}, 16'h0015);
        rd(8'h20, d); check(d, 16'h0000);
        $display("test remap done");
    endtask : t_remap
    task t_route;
        logic [15:0] d;
        rp_val[5] <= 1'b1;
        rp_val[181] <= 1'b1;
        wr(`OFS_EXTERNAL_INTERRUPT_ONE_SEL, 16'h0500);
        cyc(1); check({15'h0, ext1}, 16'h0001);
        wr(`OFS_EXTERNAL_INTERRUPT_ONE_SEL, 16'h0000);
        cyc(1); check({15'h0, ext1}, 16'h0000);
        wr(`OFS_EXTERNAL_INTERRUPT_TWO_SEL, 16'h00B5);
        cyc(1); check({15'h0, ext2}, 16'h0001);
        wr(`OFS_EXTERNAL_INTERRUPT_TWO_SEL, 16'h0001);
        cyc(1); check({15'h0, ext2}, 16'h0000);
        rd(`OFS_STATUS, d); check(d, 16'h0006);
        $display("test route done");
    endtask : t_route
    task t_notify;
        logic [15:0] d;
        wr(`OFS_CN_EN, 16'h0008);
        wr(`OFS_IRQ_EN, 16'h0001);
        wr(`OFS_CLEAR, 16'h0007);
        cyc(1); check({15'h0, irq}, 16'h0000);
        drv_val[3] <= 1'b1;
        cyc(2); check({15'h0, irq}, 16'h0001);
        rd(`OFS_STATUS, d); check(d, 16'h0001);
        wr(`OFS_CLEAR, 16'h0001);
        cyc(2); check({15'h0, irq}, 16'h0000);
        drv_val[5] <= 1'b1;
        cyc(3); rd(`OFS_STATUS, d); check(d, 16'h0000);
        sleep_mode <= 1'b1;
        drv_val[3] <= 1'b0;
        cyc(3); check({15'h0, irq}, 16'h0001);
        sleep_mode <= 1'b0;
        cyc(2); wr(`OFS_CLEAR, 16'h0001);
        cyc(2); check({15'h0, irq}, 16'h0000);
        $display("test notify done");
    endtask : t_notify
    task t_pulls;
        logic [15:0] d;
        wr(`OFS_PULLUP, 16'h00F0);
        wr(`OFS_PULLDOWN, 16'h000F);
        cyc(1);
        check(pu, 16'h00F0);
        check(pd, 16'h000F);
        rd(`OFS_IRQ_EN, d); check(d, 16'h0001);
        cyc(1); rd(`OFS_PIN_LEVEL, d); check(d, 16'h0020);
        $display("test pulls done");
    endtask : t_pulls
    task stop_test;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_remap();
        t_route();
        t_notify();
        t_pulls();
        stop_test();
    end
endmodule : pin_change_notify_and_remap_tb

// [sim/pin_notify_partner.sv]
// External pin model facing the pin notify block
`timescale 1ns/1ns
module pin_notify_partner (
    // Pin drive from the bench, pull enables from the block
    input  wire logic [15:0]  drv_val,
    input  wire logic [15:0]  drv_en,
    input  wire logic [15:0]  pu_en,
    input  wire logic [15:0]  pd_en,
    input  wire logic [181:0] rp_val,
    // Levels seen by the block
    output logic [15:0]       port_lvl,
    output logic [181:0]      rp_lvl
);
    // Released pins settle to the enabled pull, else away from the drive
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            port_lvl[i] = drv_en[i] ? drv_val[i] : pu_en[i] ? 1'b1 :
                          pd_en[i] ? 1'b0 : ~drv_val[i];
        end
    end
    // Position zero is not a remappable pin
    assign rp_lvl = {rp_val[181:1], 1'b0};
endmodule : pin_notify_partner

// [verilog/pin_change_notify_and_remap.sv]
// Pin change notify, weak pull control and pin remap selectors
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "pin_notify_defs.svh"

module pin_change_notify_and_remap
    import pin_notify_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    // Register port
    input  wire bus_req_type            bus_req,
    output logic [15:0]                 rd_data,
    // Port pins
    input  wire logic [`PORT_PINS-1:0]  port_in,
    input  wire logic                   sleep_mode,
    output logic [`PORT_PINS-1:0]       weak_pullup_enable_bits,
    output logic [`PORT_PINS-1:0]       weak_pulldown_enable_bits,
    // Remappable pins
    input  wire logic [`RP_WIDTH-1:0]   rp_in,
    output logic                        external_interrupt_one,
    output logic                        external_interrupt_two,
    output out_func_type                out_func,
    // Interrupt
    output logic                        pin_change_notify
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Zero selects ground; values above the last pin also read low
    function automatic logic sel_pin(input logic [7:0] sel,
                                     input logic [`RP_WIDTH-1:0] pins);
        logic v;
        v = 1'b0;
        if (sel != 8'h00 && sel <= 8'(`RP_MAX)) begin
            v = pins[sel];
        end
        return v;
    endfunction : sel_pin

    function automatic logic hit(input bus_req_type r, input logic [7:0] a);
        return r.wr && r.addr == a;
    endfunction : hit

    logic [7:0]            external_interrupt_one_source_field;
    logic [7:0]            external_interrupt_two_source_field;
    logic [`PORT_PINS-1:0] change_irq_enable_bits;
    logic [`PORT_PINS-1:0] snapshot;
    logic [`ST_BITS-1:0]   status;
    logic [`ST_BITS-1:0]   irq_en;
    logic [`ST_BITS-1:0]   events;
    logic                  level_change_event;
    logic                  next_external_interrupt_one;
    logic                  next_external_interrupt_two;

    // ------------------------------------------------------------------
    // Remap selectors
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            external_interrupt_one_source_field <= `SEL_RESET;
            external_interrupt_two_source_field <= `SEL_RESET;
            out_func          <= {`FUNC_RESET, `FUNC_RESET};
        end else begin
            if (hit(bus_req, `OFS_EXTERNAL_INTERRUPT_ONE_SEL)) begin
                external_interrupt_one_source_field <=
                    bus_req.wdata[`EXTERNAL_INTERRUPT_ONE_MSB:`EXTERNAL_INTERRUPT_ONE_LSB];
            end
            if (hit(bus_req, `OFS_EXTERNAL_INTERRUPT_TWO_SEL)) begin
                external_interrupt_two_source_field <=
                    bus_req.wdata[`EXTERNAL_INTERRUPT_TWO_MSB:`EXTERNAL_INTERRUPT_TWO_LSB];
            end
            if (hit(bus_req, `OFS_OUT_SEL)) begin
                out_func.pin177_output_func_field <=
                    bus_req.wdata[`F177_MSB:`F177_LSB];
                out_func.pin176_output_func_field <=
                    bus_req.wdata[`F176_MSB:`F176_LSB];
            end
        end
    end

    assign next_external_interrupt_one = sel_pin(external_interrupt_one_source_field, rp_in);
    assign next_external_interrupt_two = sel_pin(external_interrupt_two_source_field, rp_in);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            external_interrupt_one <= 1'b0;
            external_interrupt_two <= 1'b0;
        end else begin
            external_interrupt_one <= next_external_interrupt_one;
            external_interrupt_two <= next_external_interrupt_two;
        end
    end

    // ------------------------------------------------------------------
    // Change notify and pull enables
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            change_irq_enable_bits    <= `REG_RESET;
            weak_pullup_enable_bits   <= `REG_RESET;
            weak_pulldown_enable_bits <= `REG_RESET;
        end else begin
            if (hit(bus_req, `OFS_CN_EN)) begin
                change_irq_enable_bits <= bus_req.wdata;
            end
            if (hit(bus_req, `OFS_PULLUP)) begin
                weak_pullup_enable_bits <= bus_req.wdata;
            end
            if (hit(bus_req, `OFS_PULLDOWN)) begin
                weak_pulldown_enable_bits <= bus_req.wdata;
            end
        end
    end

    // Reference level is frozen in sleep so a change made while the
    // clock is stopped is still seen on the first edge after wake
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            snapshot <= `REG_RESET;
        end else if (!sleep_mode) begin
            snapshot <= port_in;
        end
    end

    assign level_change_event =
        |((port_in ^ snapshot) & change_irq_enable_bits);

    // ------------------------------------------------------------------
    // Status, enable and interrupt
    // ------------------------------------------------------------------
    assign events = {next_external_interrupt_two & ~external_interrupt_two,
                     next_external_interrupt_one & ~external_interrupt_one,
                     level_change_event};

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status <= '0;
        end else if (hit(bus_req, `OFS_CLEAR)) begin
            status <= (status & ~bus_req.wdata[`ST_BITS-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_en <= '0;
        end else if (hit(bus_req, `OFS_IRQ_EN)) begin
            irq_en <= bus_req.wdata[`ST_BITS-1:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_change_notify <= 1'b0;
        end else begin
            pin_change_notify <= |(status & irq_en);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= `REG_RESET;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `OFS_EXTERNAL_INTERRUPT_ONE_SEL:  rd_data <= {external_interrupt_one_source_field, 8'h00};
                `OFS_EXTERNAL_INTERRUPT_TWO_SEL:  rd_data <= {8'h00, external_interrupt_two_source_field};
                `OFS_OUT_SEL:   rd_data <= {2'h0,
                                    out_func.pin177_output_func_field,
                                    2'h0,
                                    out_func.pin176_output_func_field};
                `OFS_CN_EN:     rd_data <= change_irq_enable_bits;
                `OFS_PULLUP:    rd_data <= weak_pullup_enable_bits;
                `OFS_PULLDOWN:  rd_data <= weak_pulldown_enable_bits;
                `OFS_STATUS:    rd_data <= {13'h0000, status};
                `OFS_IRQ_EN:    rd_data <= {13'h0000, irq_en};
                `OFS_PIN_LEVEL: rd_data <= port_in;
                default:        rd_data <= `REG_RESET;
            endcase
        end else begin
            rd_data <= `REG_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    change_latch_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        level_change_event |=> status[`ST_CHANGE])
        else $error("enabled pin change not latched");

    change_mask_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        $rose(status[`ST_CHANGE]) |->
            $past(|((port_in ^ snapshot) & change_irq_enable_bits)))
        else $error("change flag set without enabled change");

    sleep_hold_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        sleep_mode |=> snapshot == $past(snapshot))
        else $error("reference moved during sleep");

    irq_level_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        level_change_event && irq_en[`ST_CHANGE] |-> ##2 pin_change_notify)
        else $error("change did not raise interrupt");

    external_interrupt_one_route_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ##1 external_interrupt_one ==
            $past(sel_pin(external_interrupt_one_source_field, rp_in)))
        else $error("interrupt one routing wrong");

    ground_sel_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        external_interrupt_two_source_field == 8'h00 |=> !external_interrupt_two)
        else $error("zero selector not tied low");

    external_interrupt_two_write_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_EXTERNAL_INTERRUPT_TWO_SEL) |=>
            external_interrupt_two_source_field == $past(bus_req.wdata[7:0]))
        else $error("interrupt two selector not stored");

    func177_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_OUT_SEL) |=>
            out_func.pin177_output_func_field == $past(bus_req.wdata[13:8]))
        else $error("pin 177 function not stored");

    func176_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_OUT_SEL) |=>
            out_func.pin176_output_func_field == $past(bus_req.wdata[5:0]))
        else $error("pin 176 function not stored");

    unused_zero_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `OFS_OUT_SEL |=>
            rd_data[15:14] == 2'h0 && rd_data[7:6] == 2'h0)
        else $error("unimplemented bits read nonzero");

    pull_write_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_PULLDOWN) |=>
            weak_pulldown_enable_bits == $past(bus_req.wdata))
        else $error("pull-down enables not stored");

    reset_sel_a: assert property (
        @(posedge mclk)
        $rose(reset_n) |-> external_interrupt_one_source_field == 8'h00 &&
            external_interrupt_two_source_field == 8'h00 && out_func == '0)
        else $error("selectors not cleared by reset");

    reset_route_a: assert property (
        @(posedge mclk)
        $rose(reset_n) |-> !external_interrupt_one && !external_interrupt_two)
        else $error("routed inputs not low after reset");

    external_interrupt_two_route_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        ##1 external_interrupt_two ==
            $past(sel_pin(external_interrupt_two_source_field, rp_in)))
        else $error("interrupt two routing wrong");

    external_interrupt_one_write_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_EXTERNAL_INTERRUPT_ONE_SEL) |=>
            external_interrupt_one_source_field == $past(bus_req.wdata[15:8]))
        else $error("interrupt one selector not stored");

    external_interrupt_one_ground_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        external_interrupt_one_source_field == 8'h00 |=> !external_interrupt_one)
        else $error("zero selector one not tied low");

    high_sel_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        external_interrupt_one_source_field > 8'hB5 |=> !external_interrupt_one)
        else $error("selector beyond last pin not low");

    external_interrupt_one_unused_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `OFS_EXTERNAL_INTERRUPT_ONE_SEL |=>
            rd_data[7:0] == 8'h00)
        else $error("selector one low byte reads nonzero");

    external_interrupt_two_unused_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `OFS_EXTERNAL_INTERRUPT_TWO_SEL |=>
            rd_data[15:8] == 8'h00)
        else $error("selector two high byte reads nonzero");

    out177_read_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `OFS_OUT_SEL |=>
            rd_data[13:8] == $past(out_func.pin177_output_func_field))
        else $error("pin 177 function reads wrong");

    out176_read_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `OFS_OUT_SEL |=>
            rd_data[5:0] == $past(out_func.pin176_output_func_field))
        else $error("pin 176 function reads wrong");

    pullup_write_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_PULLUP) |=>
            weak_pullup_enable_bits == $past(bus_req.wdata))
        else $error("pull-up enables not stored");

    pullup_read_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        bus_req.rd && bus_req.addr == `OFS_PULLUP |=>
            rd_data == $past(weak_pullup_enable_bits))
        else $error("pull-up enables read wrong");

    cn_en_write_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_CN_EN) |=>
            change_irq_enable_bits == $past(bus_req.wdata))
        else $error("change enables not stored");

    snapshot_track_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !sleep_mode |=> snapshot == $past(port_in))
        else $error("reference level not captured");

    sleep_catch_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        sleep_mode && level_change_event |=> status[`ST_CHANGE])
        else $error("change in sleep not latched");

    status_sticky_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        status[`ST_CHANGE] && !hit(bus_req, `OFS_CLEAR) |=>
            status[`ST_CHANGE])
        else $error("change flag lost without clear");

    status_clear_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        hit(bus_req, `OFS_CLEAR) && bus_req.wdata[0] &&
            !level_change_event |=> !status[`ST_CHANGE])
        else $error("change flag not cleared");

    irq_follow_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        |(status & irq_en) |=> pin_change_notify)
        else $error("interrupt not raised for enabled status");

    irq_clear_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !(|(status & irq_en)) |=> !pin_change_notify)
        else $error("interrupt high without enabled status");

endmodule : pin_change_notify_and_remap

// [verilog/pin_notify_defs.svh]
// Offsets, field positions, reset values and sizes of the pin notify block
// Operation
// - A change on an enabled input pin raises an interrupt request.
// - Change detection keeps its reference through sleep, so a change is caught.
// - Each port pin has its own change enable; a cleared bit suppresses it.
// - Each pin has separate weak pull-up and pull-down enables.
// - The upper byte of the first input select picks the source of interrupt one.
// - Selector zero ties the input low; n connects remappable pin n up to 181.
// - The lower byte of the second input select picks the source of interrupt two.
// - Bits 13-8 of the output select pick the function for pin 177.
// - Bits 5-0 of the output select pick the function for pin 176.
// - Unimplemented remap bits ignore writes and read as zero.
`ifndef PIN_NOTIFY_DEFS_SVH
`define PIN_NOTIFY_DEFS_SVH

`define PORT_PINS      16
`define RP_MAX         181
`define RP_WIDTH       182

// Register byte offsets
`define OFS_EXTERNAL_INTERRUPT_ONE_SEL   8'h00
`define OFS_EXTERNAL_INTERRUPT_TWO_SEL   8'h02
`define OFS_OUT_SEL    8'h04
`define OFS_CN_EN      8'h06
`define OFS_PULLUP     8'h08
`define OFS_PULLDOWN   8'h0A
`define OFS_STATUS     8'h0C
`define OFS_CLEAR      8'h0E
`define OFS_IRQ_EN     8'h10
`define OFS_PIN_LEVEL  8'h12

// Field positions
`define EXTERNAL_INTERRUPT_ONE_MSB       15
`define EXTERNAL_INTERRUPT_ONE_LSB       8
`define EXTERNAL_INTERRUPT_TWO_MSB       7
`define EXTERNAL_INTERRUPT_TWO_LSB       0
`define F177_MSB       13
`define F177_LSB       8
`define F176_MSB       5
`define F176_LSB       0

// Status bits
`define ST_CHANGE      0
`define ST_EXTERNAL_INTERRUPT_ONE        1
`define ST_EXTERNAL_INTERRUPT_TWO        2
`define ST_BITS        3

`define SEL_RESET      8'h00
`define FUNC_RESET     6'h00
`define REG_RESET      16'h0000

`endif

// [verilog/pin_notify_pkg.sv]
// Types shared by the pin notify block
package pin_notify_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

    typedef struct packed {
        logic [5:0] pin177_output_func_field;
        logic [5:0] pin176_output_func_field;
    } out_func_type;

endpackage : pin_notify_pkg
